// ===== src/status_io_pkg.sv
package status_io_pkg;

  // clock and line timing
  localparam int CLK_HZ        = 125_000_000; // core clock rate
  localparam int MAX_BAUD      = 3_000_000;   // ceiling on serial rate
  localparam int DEFAULT_BAUD  = 115_200;     // rate out of reset
  localparam int LAMP_TIME_MS  = 50;          // visible lamp pulse
  localparam int LAMP_CYCLES   = CLK_HZ / 1000 * LAMP_TIME_MS;
  // least divisor rounds up so the rate never exceeds the ceiling
  localparam int BAUD_DIV_MIN_I = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;

  localparam int             DIV_W        = 16;
  localparam logic [15:0]    BAUD_DIV_MIN = 16'(BAUD_DIV_MIN_I);
  localparam logic [15:0]    BAUD_DIV_RST = 16'(CLK_HZ / DEFAULT_BAUD);
  // start pulse is issued two cycles ahead of the lead count end
  localparam logic [15:0]    LEAD_TRIM    = 16'h0002;
  localparam logic [15:0]    CNT_ONE      = 16'h0001;

  // register byte offsets
  localparam logic [7:0] PIN_CFG_OFS    = 8'h00; // stored pin functions
  localparam logic [7:0] BAUD_DIV_OFS   = 8'h04; // bit period in cycles
  localparam logic [7:0] STATUS_OFS     = 8'h08; // live state, read only
  localparam logic [7:0] ACTIVE_CFG_OFS = 8'h0c; // functions in force

  // status bit positions
  localparam int ST_DRV_EN  = 0;
  localparam int ST_TX_LAMP = 1;
  localparam int ST_RX_LAMP = 2;
  localparam int ST_SUSPEND = 3;
  localparam int ST_CHARGER = 4;
  localparam int ST_TX_BUSY = 5;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pin function codes, one nibble per pin
  localparam int FUNC_W = 4;
  typedef enum logic [FUNC_W-1:0] {
    FUNC_OFF,
    FUNC_DRIVER_EN,
    FUNC_TX_LAMP,
    FUNC_RX_LAMP,
    FUNC_ANY_LAMP,
    FUNC_POWER_EN_N,
    FUNC_SLEEP_N,
    FUNC_CHARGER,
    FUNC_CHARGER_N
  } pin_func_t;

  // default image: pin0 driver enable, pin1 rx, pin2 tx, pin3 sleep
  localparam logic [15:0] PIN_CFG_RST = {FUNC_SLEEP_N, FUNC_TX_LAMP,
                                         FUNC_RX_LAMP, FUNC_DRIVER_EN};

  // transmit framing states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LEAD,
    TX_SHIFT
  } tx_state_t;

endpackage : status_io_pkg

// ===== src/lamp_one_shot.sv
`timescale 1ns/1ps
// retriggerable pulse stretcher for one activity lamp
module lamp_one_shot #(
  parameter int LEN = 6_250_000 // pulse length in cycles
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trigger,  // one-cycle activity event
  output logic      active    // high for LEN cycles after last event
);

  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LEN_C = CW'(LEN);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [CW-1:0] cnt_r;   // cycles left in the pulse
  logic [CW-1:0] cnt_nxt;
  logic          active_r;

  // each new event restarts the full length
  assign cnt_nxt = trigger           ? LEN_C :
                   (cnt_r != '0)     ? cnt_r - ONE_C : '0;

  // stretch state, cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= '0;
      active_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      active_r <= (cnt_nxt != '0);
    end
  end

  assign active = active_r;

endmodule : lamp_one_shot

// ===== src/uart_status_output_logic.sv
`timescale 1ns/1ps
module uart_status_output_logic
  import status_io_pkg::*;
#(
  parameter int N_PINS   = 4,           // configurable pins
  parameter int LAMP_LEN = LAMP_CYCLES  // lamp pulse cycles
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // uart core side
  input  wire logic              tx_char_ready,
  input  wire logic              tx_stop_due,
  input  wire logic              rx_activity,
  output logic                   tx_start_go,
  // usb state
  input  wire logic              usb_suspend,
  input  wire logic              dcp_detected,
  input  wire logic              usb_bus_reset,
  // configurable pins
  output logic [N_PINS-1:0]      configurable_io_pins_out,
  output logic [N_PINS-1:0]      configurable_io_pins_oe
);

  localparam int CFG_W = N_PINS * FUNC_W;

  // one clock domain, so every check below shares these
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------- register bus ----------------
  logic              aw_full_r;   // write address held
  logic [7:0]        aw_addr_r;
  logic              w_full_r;    // write data held
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  logic [15:0]       pin_cfg_r;     // stored image, software written
  logic [CFG_W-1:0]  active_cfg_r;  // image in force on the pins
  logic [15:0]       baud_div_r;    // bit period in cycles

  // handshake decode
  wire aw_take   = s_axi_awvalid & awready_r;
  wire w_take    = s_axi_wvalid & wready_r;
  wire ar_take   = s_axi_arvalid & arready_r;
  wire wr_fire   = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_nxt    = (aw_full_r & ~wr_fire) | aw_take;
  wire w_nxt     = (w_full_r & ~wr_fire) | w_take;
  wire bv_nxt    = wr_fire | (bvalid_r & ~s_axi_bready);
  wire rv_nxt    = ar_take | (rvalid_r & ~s_axi_rready);

  // write address decode, word aligned
  wire wr_cfg    = aw_addr_r[7:2] == PIN_CFG_OFS[7:2];
  wire wr_baud   = aw_addr_r[7:2] == BAUD_DIV_OFS[7:2];
  wire wr_ro     = (aw_addr_r[7:2] == STATUS_OFS[7:2]) |
                   (aw_addr_r[7:2] == ACTIVE_CFG_OFS[7:2]);
  wire wr_hit    = wr_cfg | wr_baud | wr_ro;

  // byte lanes merge into the 16-bit registers
  wire [15:0] lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [15:0] cfg_merge = (pin_cfg_r & ~lane_mask) |
                          (w_data_r[15:0] & lane_mask);
  wire [15:0] div_merge = (baud_div_r & ~lane_mask) |
                          (w_data_r[15:0] & lane_mask);
  // too small a divisor is raised to the floor
  wire [15:0] div_clamp = (div_merge < BAUD_DIV_MIN) ? BAUD_DIV_MIN
                                                      : div_merge;

  // ---------------- transmit framing ----------------
  tx_state_t         tx_state_r;
  tx_state_t         tx_state_nxt;
  logic [15:0]       lead_cnt_r;
  logic [15:0]       lead_cnt_nxt;
  logic              drv_en_r;      // line driver enable level
  logic              drv_en_nxt;
  logic              start_go_r;
  logic              start_go_nxt;

  // framing sequence; new characters wait outside idle
  always_comb begin
    tx_state_nxt = tx_state_r;
    lead_cnt_nxt = lead_cnt_r;
    drv_en_nxt   = drv_en_r;
    start_go_nxt = 1'b0;
    unique case (tx_state_r)
      TX_IDLE: begin
        if (tx_char_ready) begin
          tx_state_nxt = TX_LEAD;
          drv_en_nxt   = 1'b1;
          lead_cnt_nxt = baud_div_r - LEAD_TRIM;
        end
      end
      TX_LEAD: begin
        // start bit begins at the edge that samples the go pulse
        if (lead_cnt_r == '0) begin
          start_go_nxt = 1'b1;
          tx_state_nxt = TX_SHIFT;
        end else begin
          lead_cnt_nxt = lead_cnt_r - CNT_ONE;
        end
      end
      TX_SHIFT: begin
        // stop_due marks the edge where the stop bit starts
        if (tx_stop_due) begin
          tx_state_nxt = TX_IDLE;
          drv_en_nxt   = 1'b0;
        end
      end
    endcase
  end

  // framing registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r <= TX_IDLE;
      lead_cnt_r <= '0;
      drv_en_r   <= 1'b0;
      start_go_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      lead_cnt_r <= lead_cnt_nxt;
      drv_en_r   <= drv_en_nxt;
      start_go_r <= start_go_nxt;
    end
  end

  // ---------------- activity lamps ----------------
  logic tx_lamp_on;  // stretched transmit activity
  logic rx_lamp_on;  // stretched receive activity

  lamp_one_shot #(.LEN(LAMP_LEN)) u_tx_lamp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trigger (start_go_r),
    .active  (tx_lamp_on)
  );

  lamp_one_shot #(.LEN(LAMP_LEN)) u_rx_lamp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trigger (rx_activity),
    .active  (rx_lamp_on)
  );

  // charger only while a charging port holds us suspended
  wire charger_on = dcp_detected & usb_suspend;

  // per-pin drive as {oe, out}; spare codes float the pin
  function automatic logic [1:0] pin_drive(
    input logic [FUNC_W-1:0] code,
    input logic              en,
    input logic              tx_on,
    input logic              rx_on,
    input logic              susp,
    input logic              chg
  );
    logic [1:0] d;
    d = 2'b00;
    case (pin_func_t'(code))
      FUNC_OFF:        d = 2'b00;
      FUNC_DRIVER_EN:  d = {1'b1, en};
      FUNC_TX_LAMP:    d = {tx_on, 1'b0};
      FUNC_RX_LAMP:    d = {rx_on, 1'b0};
      FUNC_ANY_LAMP:   d = {tx_on | rx_on, 1'b0};
      FUNC_POWER_EN_N: d = {1'b1, susp};
      FUNC_SLEEP_N:    d = {1'b1, ~susp};
      FUNC_CHARGER:    d = {1'b1, chg};
      FUNC_CHARGER_N:  d = {1'b1, ~chg};
      default:         d = 2'b00;
    endcase
    return d;
  endfunction : pin_drive

  logic [N_PINS-1:0] pin_out_r;
  logic [N_PINS-1:0] pin_oe_r;
  logic [N_PINS-1:0] pin_out_nxt;
  logic [N_PINS-1:0] pin_oe_nxt;

  // enable uses its next value so the pin moves on the framing edge
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_pin
      assign {pin_oe_nxt[gi], pin_out_nxt[gi]} =
        pin_drive(active_cfg_r[gi*FUNC_W +: FUNC_W], drv_en_nxt,
                  tx_lamp_on, rx_lamp_on, usb_suspend, charger_on);

      any_lamp_a: assert property (
        (active_cfg_r[gi*FUNC_W +: FUNC_W] == FUNC_ANY_LAMP) &&
        !usb_bus_reset && (tx_lamp_on || rx_lamp_on)
        |=> pin_oe_r[gi] && !pin_out_r[gi])
        else $error("combined lamp not lit on activity");

      charger_pin_a: assert property (
        (active_cfg_r[gi*FUNC_W +: FUNC_W] == FUNC_CHARGER) &&
        !usb_bus_reset |=> pin_out_r[gi] == $past(charger_on))
        else $error("charger output wrong for suspend state");
    end
  endgenerate

  // pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  // ---------------- configuration ----------------
  // functions change only when the stored image is rescanned, so
  // software writes take effect after the next usb bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_cfg_r <= CFG_W'(PIN_CFG_RST);
    end else if (usb_bus_reset) begin
      active_cfg_r <= CFG_W'(pin_cfg_r);
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cfg_r  <= PIN_CFG_RST;
      baud_div_r <= BAUD_DIV_RST;
    end else if (wr_fire) begin
      if (wr_cfg) pin_cfg_r <= cfg_merge;
      if (wr_baud) baud_div_r <= div_clamp;
    end
  end

  // read decode
  wire [31:0] status_word = {26'h0, tx_state_r != TX_IDLE,
                             charger_on, usb_suspend, rx_lamp_on,
                             tx_lamp_on, drv_en_r};
  wire rd_cfg    = s_axi_araddr[7:2] == PIN_CFG_OFS[7:2];
  wire rd_baud   = s_axi_araddr[7:2] == BAUD_DIV_OFS[7:2];
  wire rd_stat   = s_axi_araddr[7:2] == STATUS_OFS[7:2];
  wire rd_act    = s_axi_araddr[7:2] == ACTIVE_CFG_OFS[7:2];
  wire rd_hit    = rd_cfg | rd_baud | rd_stat | rd_act;
  wire [31:0] rd_word = rd_cfg  ? {16'h0, pin_cfg_r}  :
                        rd_baud ? {16'h0, baud_div_r} :
                        rd_stat ? status_word         :
                        rd_act  ? 32'(active_cfg_r)   : 32'h0;

  // write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_nxt;
      w_full_r  <= w_nxt;
      awready_r <= ~aw_nxt;
      wready_r  <= ~w_nxt;
      bvalid_r  <= bv_nxt;
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      // unmapped writes answer with an error and change nothing
      if (wr_fire) bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel, one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rv_nxt;
      rvalid_r  <= rv_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // outputs straight from flops
  assign s_axi_awready            = awready_r;
  assign s_axi_wready             = wready_r;
  assign s_axi_bvalid             = bvalid_r;
  assign s_axi_bresp              = bresp_r;
  assign s_axi_arready            = arready_r;
  assign s_axi_rvalid             = rvalid_r;
  assign s_axi_rdata              = rdata_r;
  assign s_axi_rresp              = rresp_r;
  assign tx_start_go              = start_go_r;
  assign configurable_io_pins_out = pin_out_r;
  assign configurable_io_pins_oe  = pin_oe_r;

  // ---------------- checks ----------------

  // helper: cycles since the driver enable rose
  logic [15:0] en_age_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) en_age_r <= '0;
    else en_age_r <= drv_en_nxt ? (drv_en_r ? en_age_r + CNT_ONE : '0)
                                : '0;
  end

  sequence frame_end_s;
    (tx_state_r == TX_SHIFT) && tx_stop_due;
  endsequence

  lead_time_a: assert property (
    start_go_r |-> drv_en_r && (en_age_r == baud_div_r - CNT_ONE))
    else $error("start pulse not one bit after enable");

  trail_drop_a: assert property (
    frame_end_s |=> !drv_en_r ##0 !start_go_r)
    else $error("enable not dropped at stop bit");

  idle_quiet_a: assert property (
    (tx_state_r == TX_IDLE) && !tx_char_ready |=> !drv_en_r)
    else $error("enable active outside a character");

  baud_floor_a: assert property (
    baud_div_r >= BAUD_DIV_MIN)
    else $error("bit period below rate ceiling");

  lamp_stretch_a: assert property (
    start_go_r |=> tx_lamp_on [*8])
    else $error("tx lamp pulse not stretched");

  rx_lamp_a: assert property (
    rx_activity |=> rx_lamp_on ##0 status_word[ST_RX_LAMP])
    else $error("rx lamp not lit after activity");

  cfg_hold_a: assert property (
    !usb_bus_reset |=> $stable(active_cfg_r))
    else $error("pin functions changed outside rescan");

  power_en_a: assert property (
    (active_cfg_r[FUNC_W-1:0] == FUNC_POWER_EN_N) && !usb_bus_reset
    |=> pin_oe_r[0] && (pin_out_r[0] == $past(usb_suspend)))
    else $error("power enable not high in suspend");

  // default image puts the sleep function on the top pin
  sleep_pin_a: assert property (
    (active_cfg_r[CFG_W-1 -: FUNC_W] == FUNC_SLEEP_N) && !usb_bus_reset
    |=> pin_oe_r[N_PINS-1] && (pin_out_r[N_PINS-1] != $past(usb_suspend)))
    else $error("sleep pin wrong for suspend state");

endmodule : uart_status_output_logic

// ===== bench/status_partner.sv
`timescale 1ns/1ps
// far side: uart shifter, lamp pull-ups, echo gate
module status_partner #(
  parameter int DIV  = 42, // bit period in cycles
  parameter int BITS = 9   // start plus data bits before stop
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tx_start_go,
  input  wire logic [3:0] pins_out,
  input  wire logic [3:0] pins_oe,
  input  wire logic       rx_line,
  output logic            tx_stop_due = 1'b0,
  output logic [3:0]      pin_level,
  output logic            rxd_to_uart
);
  int cnt_r = 0; // cycles left in the frame body
  // floating pins read high through the lamp pull-ups
  assign pin_level = (pins_oe & pins_out) | ~pins_oe;
  // own echo masked while the line driver is on
  assign rxd_to_uart = pin_level[0] | rx_line;
  // stop flag comes one cycle ahead of the stop bit itself
  always @(posedge aclk) begin
    tx_stop_due <= aresetn && !tx_start_go && (cnt_r == 1);
    if (!aresetn) cnt_r <= 0;
    else if (tx_start_go) cnt_r <= BITS * DIV - 1;
    else if (cnt_r > 0) cnt_r <= cnt_r - 1;
  end
endmodule : status_partner

// ===== bench/uart_status_output_logic_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  err_count++; end end
module uart_status_output_logic_bench
  import status_io_pkg::*;
;
  typedef struct packed {logic s; logic d; logic [3:0] o;} row_t;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, tx_start_go, stop_due;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic tx_char_ready = 0, rx_activity = 0, usb_suspend = 0;
  logic dcp_detected = 0, usb_bus_reset = 0;
  logic [3:0] pins_out, pins_oe, lvl, wstrb = 4'hf;
  logic rxd, en_ok, rx_line = 1'b1;
  int err_count = 0, tests_run = 0, n;
  // suspend and charger inputs beside the pin levels they give
  row_t rows [4] = '{'{1'b0, 1'b0, 4'ha}, '{1'b0, 1'b1, 4'ha},
                     '{1'b1, 1'b0, 4'h9}, '{1'b1, 1'b1, 4'h5}};
  always #4 aclk = ~aclk; // 125 MHz
  uart_status_output_logic #(.N_PINS(4), .LAMP_LEN(20)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_char_ready(tx_char_ready),
    .tx_stop_due(stop_due), .rx_activity(rx_activity),
    .tx_start_go(tx_start_go), .usb_suspend(usb_suspend),
    .dcp_detected(dcp_detected), .usb_bus_reset(usb_bus_reset),
    .configurable_io_pins_out(pins_out),
    .configurable_io_pins_oe(pins_oe));
  status_partner #(.DIV(42), .BITS(9)) far_side (
    .aclk(aclk), .aresetn(aresetn), .tx_start_go(tx_start_go),
    .pins_out(pins_out), .pins_oe(pins_oe), .rx_line(rx_line),
    .tx_stop_due(stop_due), .pin_level(lvl), .rxd_to_uart(rxd));
  // verdict and end of run
  task automatic end_sim;
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // one write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    if (bvalid !== 1'b1) err_count++;
    bready <= 0;
    @(posedge aclk);
  endtask : wr
  // one read; rready held until the answer is sampled
  task automatic rdr(input logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata; resp = rresp;
    if (rvalid !== 1'b1) err_count++;
    rready <= 0;
    @(posedge aclk);
  endtask : rdr
  // new functions reach the pins only through a bus reset
  task automatic reload;
    usb_bus_reset <= 1;
    @(posedge aclk);
    usb_bus_reset <= 0;
    repeat (3) @(posedge aclk);
  endtask : reload
  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge aclk);
    `CHK("oe in reset", 4'h0, pins_oe)
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    `CHK("default oe", 4'h9, pins_oe)
    `CHK("sleep pin", 1'b1, pins_out[3])
    rdr(PIN_CFG_OFS);
    `CHK("pin cfg rst", 32'h6231, rd)
    rdr(8'h10);
    `CHK("unmapped rd", RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h0, rd)
    wr(8'h10, 32'h1);
    `CHK("unmapped wr", RESP_SLVERR, resp)
    // stored image waits for a bus reset
    wr(PIN_CFG_OFS, 32'h8765);
    rdr(ACTIVE_CFG_OFS);
    `CHK("not yet live", 32'h6231, rd)
    reload();
    rdr(ACTIVE_CFG_OFS);
    `CHK("now live", 32'h8765, rd)
    // power, sleep and charger pins for every input pair
    foreach (rows[i]) begin
      usb_suspend <= rows[i].s; dcp_detected <= rows[i].d;
      repeat (3) @(posedge aclk);
      `CHK("status oe", 4'hf, pins_oe)
      `CHK("status pins", rows[i].o, pins_out)
      rdr(STATUS_OFS);
      `CHK("st charger", rows[i].s & rows[i].d, rd[ST_CHARGER])
    end
    usb_suspend <= 0; dcp_detected <= 0;
    // only the strobed lane lands; the low byte keeps its reset value
    wstrb <= 4'h2;
    wr(BAUD_DIV_OFS, 32'hffff_0100);
    wstrb <= 4'hf;
    rdr(BAUD_DIV_OFS);
    `CHK("baud lane", 32'h13d, rd)
    // divisor below the ceiling is clamped
    wr(BAUD_DIV_OFS, 32'h5);
    rdr(BAUD_DIV_OFS);
    `CHK("baud clamp", 32'h2a, rd)
    wr(PIN_CFG_OFS, 32'h4321);
    reload();
    // one character: lead of one bit, enable through the frame
    tx_char_ready <= 1; rx_line <= 0;
    @(posedge aclk);
    tx_char_ready <= 0;
    #1 `CHK("lead en", 1'b1, pins_out[0] & pins_oe[0])
    `CHK("echo masked", 1'b1, rxd)
    n = 0;
    do begin @(posedge aclk); n++; end
    while (tx_start_go !== 1'b1 && n < 100);
    `CHK("lead cycles", 42, n)
    repeat (4) @(posedge aclk);
    `CHK("tx lamp lit", 1'b0, lvl[1])
    `CHK("any lamp lit", 1'b0, lvl[3])
    en_ok = 1; n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (pins_out[0] !== 1'b1) en_ok = 0;
    end while (stop_due !== 1'b1 && n < 1000);
    `CHK("en held", 1'b1, en_ok)
    #1 `CHK("en at stop", 1'b0, pins_out[0])
    repeat (30) @(posedge aclk);
    `CHK("lamps idle", 4'he, lvl)
    `CHK("echo open", 1'b0, rxd)
    // receive lamp retriggered before it runs out
    for (int k = 0; k < 2; k++) begin
      rx_activity <= 1;
      @(posedge aclk);
      rx_activity <= 0;
      repeat (15) @(posedge aclk);
    end
    `CHK("rx retrig", 2'b00, {lvl[3], lvl[2]})
    repeat (12) @(posedge aclk);
    `CHK("rx expired", 2'b11, {lvl[3], lvl[2]})
    `CHK("rx float", 1'b0, pins_oe[2])
    end_sim();
  end
endmodule : uart_status_output_logic_bench
